/* File: cief_core.sv */
// CAN receive irq enables, status-change logic and transmit-empty flags
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Init mode holds enable register at reset
// - Sensitivity fields survive init mode
// - Enable readable always, writable outside init
// - Wake enable gates wake interrupt
// - Status-change enable gates error interrupt
// - Receiver sensitivity selects flagged receiver changes
// - Transmitter sensitivity codes none/off/passive/all
// - State fields update only without pending flag
// - Overrun enable gates error interrupt
// - Receive-full enable gates receiver interrupt
// - Empty flag one when buffer unscheduled
// - Sent or aborted buffer sets empty flag
// - Set flag and enable keep tx irq
// - Clearing empty flag clears abort ack
// - Setting empty flag clears abort request
// - Listen-only blocks flag clears and transmission
// - Scheduled buffer blocks buffer access
// - Write one clears flag, zero ignored
// - Init mode holds flag register reset
// - Transmitter leaving bus-off forces receiver ok
// - Receiver state from receive error count, bus-off from transmit error count
// - Status-change flag blocks state updates
module cief_core
  import cief_pkg::*;
#(
  parameter int unsigned NBUF = 3
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic init_request,
  input wire logic init_ack,
  input wire logic listen_only,
  input wire logic wake_flag,
  input wire logic overrun_flag,
  input wire logic rx_full_flag,
  input wire logic [8:0] rx_err_cnt,
  input wire logic [8:0] tx_err_cnt,
  input wire logic [NBUF-1:0] tx_sent,
  input wire logic [NBUF-1:0] abort_done,
  input wire logic [NBUF-1:0] buf_sel,
  output logic [NBUF-1:0] tx_schedule,
  output logic buf_access_ok,
  output logic status_change_flag,
  output logic wake_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic tx_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Receiver state from error counters
  function automatic logic [1:0] rx_code(input logic [8:0] rec, input logic [8:0] tec);
    logic [1:0] c;
    c = CIEF_ST_OK;
    if (tec > CIEF_TEC_OFF)
      c = CIEF_ST_OFF;
    else if (rec > CIEF_REC_PASS)
      c = CIEF_ST_ERR;
    else if (rec > CIEF_REC_WARN)
      c = CIEF_ST_WRN;
    return c;
  endfunction : rx_code

  // Transmitter state from its counter
  function automatic logic [1:0] tx_code(input logic [8:0] tec);
    logic [1:0] c;
    c = CIEF_ST_OK;
    if (tec > CIEF_TEC_OFF)
      c = CIEF_ST_OFF;
    else if (tec > CIEF_REC_PASS)
      c = CIEF_ST_ERR;
    else if (tec > CIEF_REC_WARN)
      c = CIEF_ST_WRN;
    return c;
  endfunction : tx_code

  // Whether a change from old to new is flagged at a sensitivity level
  function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] o,
                                    input logic [1:0] n);
    logic h;
    h = 1'b0;
    if (o != n)
    begin
      case (sens)
        2'h1: h = (o == CIEF_ST_OFF) || (n == CIEF_ST_OFF);
        2'h2: h = (o[1] != n[1]);
        2'h3: h = 1'b1;
        default: h = 1'b0;
      endcase
    end
    return h;
  endfunction : sens_hit

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the event and mode inputs

  logic [1:0] init_rq_s, init_ak_s, listen_s, wake_s, ovr_s, rxf_s;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_rq_s <= 2'h0;
      init_ak_s <= 2'h0;
      listen_s <= 2'h0;
      wake_s <= 2'h0;
      ovr_s <= 2'h0;
      rxf_s <= 2'h0;
    end
    else
    begin
      init_rq_s <= {init_rq_s[0], init_request};
      init_ak_s <= {init_ak_s[0], init_ack};
      listen_s <= {listen_s[0], listen_only};
      wake_s <= {wake_s[0], wake_flag};
      ovr_s <= {ovr_s[0], overrun_flag};
      rxf_s <= {rxf_s[0], rx_full_flag};
    end
  end

  logic init_on, init_off;
  assign init_on = init_rq_s[1] && init_ak_s[1];
  assign init_off = !init_rq_s[1] && !init_ak_s[1];

  logic wr_rier, wr_tflg, wr_stat, wr_tier, wr_arq;
  assign wr_rier = wr && (addr == CIEF_RIER_OFF) && init_off;
  assign wr_tflg = wr && (addr == CIEF_TFLG_OFF) && init_off;
  assign wr_stat = wr && (addr == CIEF_STAT_OFF);
  assign wr_tier = wr && (addr == CIEF_TIER_OFF) && init_off;
  assign wr_arq = wr && (addr == CIEF_ARQ_OFF) && init_off;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver interrupt enable register

  logic [7:0] rier_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rier_q <= CIEF_RIER_RST;
    else if (init_on)
      // Hold enables in reset, keep the sensitivity fields
      rier_q <= (CIEF_RIER_RST & 8'hC3) | (rier_q & 8'h3C);
    else if (wr_rier)
      rier_q <= wdata;
  end

  logic [1:0] rsens, tsens;
  assign rsens = rier_q[CIEF_RSENS_LSB +: 2];
  assign tsens = rier_q[CIEF_TSENS_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus state fields and status-change flag

  logic [1:0] rx_bus_state_q, tx_bus_state_q, rx_now, tx_now;
  logic csc_q, csc_set, csc_clr;
  assign tx_now = tx_code(tx_err_cnt);
  // Leaving bus-off puts the receiver back to ok as well
  assign rx_now = (tx_bus_state_q == CIEF_ST_OFF && tx_now != CIEF_ST_OFF) ?
                  CIEF_ST_OK : rx_code(rx_err_cnt, tx_err_cnt);
  assign csc_set = !csc_q && (sens_hit(rsens, rx_bus_state_q, rx_now) ||
                   sens_hit(tsens, tx_bus_state_q, tx_now));
  assign csc_clr = wr_stat && wdata[CIEF_CSC_BIT];

  // States track the counters only while no change is pending
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_bus_state_q <= CIEF_ST_OK;
      tx_bus_state_q <= CIEF_ST_OK;
    end
    else if (!csc_q)
    begin
      rx_bus_state_q <= rx_now;
      tx_bus_state_q <= tx_now;
    end
  end

  // Sticky flag, write one clears, set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      csc_q <= 1'b0;
    else if (csc_set)
      csc_q <= 1'b1;
    else if (csc_clr)
      csc_q <= 1'b0;
  end
  assign status_change_flag = csc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit empty flags, abort request and acknowledge

  logic [NBUF-1:0] txe_q, tier_q, arq_q, aak_q, txe_set, txe_clr;
  assign txe_set = ~txe_q & (tx_sent | (abort_done & arq_q));
  assign txe_clr = (wr_tflg && !listen_s[1]) ? (wdata[NBUF-1:0] & txe_q) :
                   '0;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      txe_q <= CIEF_TXE_RST[NBUF-1:0];
    else if (init_on)
      txe_q <= CIEF_TXE_RST[NBUF-1:0];
    else
      txe_q <= (txe_q & ~txe_clr) | txe_set;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tier_q <= '0;
    else if (init_on)
      tier_q <= '0;
    else if (wr_tier)
      tier_q <= wdata[NBUF-1:0];
  end

  // Request cleared when the flag sets; software sets on scheduled buffers only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      arq_q <= '0;
    else if (init_on)
      arq_q <= '0;
    else
      arq_q <= (arq_q | (wr_arq ? (wdata[NBUF-1:0] & ~txe_q) : '0)) & ~txe_set;
  end

  // Acknowledge set on abort, cleared with the flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      aak_q <= '0;
    else if (init_on)
      aak_q <= '0;
    else
      aak_q <= (aak_q | (~txe_q & abort_done & arq_q)) & ~txe_clr;
  end

  assign tx_schedule = listen_s[1] ? '0 : ~txe_q;
  assign buf_access_ok = ((buf_sel & ~txe_q) == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_irq <= 1'b0;
      error_irq <= 1'b0;
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end
    else
    begin
      wake_irq <= rier_q[CIEF_WAKE_BIT] && wake_s[1];
      error_irq <= (rier_q[CIEF_CSC_BIT] && csc_q) ||
                   (rier_q[CIEF_OVR_BIT] && ovr_s[1]);
      rx_irq <= rier_q[CIEF_RXF_BIT] && rxf_s[1];
      tx_irq <= |(txe_q & tier_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= CIEF_RD_ZERO;
    else if (rd)
    begin
      case (addr)
        CIEF_STAT_OFF: rdata <= {wake_s[1], csc_q, rx_bus_state_q, tx_bus_state_q,
                                 ovr_s[1], rxf_s[1]};
        CIEF_RIER_OFF: rdata <= rier_q;
        CIEF_TFLG_OFF: rdata <= 8'(txe_q);
        CIEF_TIER_OFF: rdata <= 8'(tier_q);
        CIEF_ARQ_OFF: rdata <= 8'(arq_q);
        CIEF_AAK_OFF: rdata <= 8'(aak_q);
        default: rdata <= CIEF_RD_ZERO;
      endcase
    end
    else
      rdata <= CIEF_RD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_rier_init;
    @(posedge clock) disable iff (!rst_n)
    init_on |=> (rier_q[7:6] == 2'h0) && (rier_q[1:0] == 2'h0);
  endproperty
  a_rier_init: assert property (p_rier_init) else $error("enable not held in init");

  property p_sens_keep;
    @(posedge clock) disable iff (!rst_n)
    init_on |=> $stable(rier_q[5:2]);
  endproperty
  a_sens_keep: assert property (p_sens_keep) else $error("sensitivity lost in init");

  property p_state_hold;
    @(posedge clock) disable iff (!rst_n)
    csc_q |=> $stable(rx_bus_state_q) && $stable(tx_bus_state_q);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved while pending");

  property p_tx_irq;
    @(posedge clock) disable iff (!rst_n)
    (|(txe_q & tier_q)) |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

  property p_listen;
    @(posedge clock) disable iff (!rst_n)
    (listen_s[1] && !init_on && txe_set == '0) |=> ($past(txe_q) == txe_q);
  endproperty
  a_listen: assert property (p_listen) else $error("flag cleared in listen");

  property p_arq_clr;
    @(posedge clock) disable iff (!rst_n)
    (txe_set != '0) |=> ((arq_q & $past(txe_set)) == '0);
  endproperty
  a_arq_clr: assert property (p_arq_clr) else $error("abort request kept");

  property p_aak_clr;
    @(posedge clock) disable iff (!rst_n)
    (txe_clr != '0 && !init_on) |=> ((aak_q & $past(txe_clr)) == '0);
  endproperty
  a_aak_clr: assert property (p_aak_clr) else $error("abort ack kept");

  sequence s_init;
    init_on;
  endsequence
  property p_txe_init;
    @(posedge clock) disable iff (!rst_n)
    s_init |=> (txe_q == CIEF_TXE_RST[NBUF-1:0]);
  endproperty
  a_txe_init: assert property (p_txe_init) else $error("flags not reset in init");

  property p_wake;
    @(posedge clock) disable iff (!rst_n)
    !rier_q[CIEF_WAKE_BIT] |=> !wake_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake irq while disabled");

endmodule : cief_core

`default_nettype wire

/* File: cief_pkg.sv */
// Package with register map, field positions and reset values for the CAN irq/tx-empty block
package cief_pkg;
  localparam int unsigned CIEF_AW = 4;
  localparam logic [3:0] CIEF_RIER_OFF = 4'h5;
  localparam logic [3:0] CIEF_TFLG_OFF = 4'h6;
  localparam logic [3:0] CIEF_STAT_OFF = 4'h4;
  localparam logic [3:0] CIEF_TIER_OFF = 4'h7;
  localparam logic [3:0] CIEF_ARQ_OFF = 4'h8;
  localparam logic [3:0] CIEF_AAK_OFF = 4'h9;
  localparam int unsigned CIEF_WAKE_BIT = 7;
  localparam int unsigned CIEF_CSC_BIT = 6;
  localparam int unsigned CIEF_RSENS_LSB = 4;
  localparam int unsigned CIEF_TSENS_LSB = 2;
  localparam int unsigned CIEF_OVR_BIT = 1;
  localparam int unsigned CIEF_RXF_BIT = 0;
  localparam logic [7:0] CIEF_RIER_RST = 8'h00;
  localparam logic [2:0] CIEF_TXE_RST = 3'h7;
  localparam logic [7:0] CIEF_STAT_RST = 8'h00;
  localparam logic [7:0] CIEF_RD_ZERO = 8'h00;
  // Receive and transmit error count thresholds
  localparam logic [8:0] CIEF_REC_WARN = 9'h060;
  localparam logic [8:0] CIEF_REC_PASS = 9'h07F;
  localparam logic [8:0] CIEF_TEC_OFF = 9'h0FF;
  // Bus state codes
  typedef enum logic [1:0]
  {
    CIEF_ST_OK = 2'h0,
    CIEF_ST_WRN = 2'h1,
    CIEF_ST_ERR = 2'h2,
    CIEF_ST_OFF = 2'h3
  } cief_state_t;
endpackage : cief_pkg

/* File: cief_can_model.sv */
// Behavioural CAN engine that sends or aborts scheduled buffers
`timescale 1ns/1ps
`default_nettype none
module cief_can_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] tx_schedule,
  input wire logic abort_mode,
  input wire logic slow,
  output logic [2:0] tx_sent,
  output logic [2:0] abort_done
);
  logic [3:0] cnt_q;
  logic [2:0] pick;
  ////////////////////////////////////////////////////////////////////////////
  // Lowest scheduled buffer goes first
  assign pick = tx_schedule & (~tx_schedule + 3'h1);
  // One pulse per buffer after a prompt or slow delay; guard stops a repeat
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      tx_sent <= 3'h0;
      abort_done <= 3'h0;
    end
    else
    begin
      tx_sent <= 3'h0;
      abort_done <= 3'h0;
      if (pick != 3'h0 && tx_sent == 3'h0 && abort_done == 3'h0)
      begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= (slow ? 4'hC : 4'h1))
        begin
          cnt_q <= 4'h0;
          if (abort_mode)
            abort_done <= pick; // Abort only when the bench asks
          else
            tx_sent <= pick;
        end
      end
    end
  end
endmodule : cief_can_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the CAN irq enable and tx-empty block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic init_request = 1'b0;
  logic init_ack = 1'b0;
  logic listen_only = 1'b0;
  logic wake_flag = 1'b0;
  logic overrun_flag = 1'b0;
  logic rx_full_flag = 1'b0;
  logic [8:0] rx_err_cnt = 9'h000;
  logic [8:0] tx_err_cnt = 9'h000;
  logic [2:0] buf_sel = 3'h0;
  logic abort_mode = 1'b0;
  logic slow = 1'b0;
  logic [2:0] tx_sent, abort_done, tx_schedule;
  logic [7:0] rdata;
  logic buf_access_ok, status_change_flag, wake_irq, error_irq, rx_irq, tx_irq;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  logic [31:0] seed = 32'h0618;
  int error_cnt = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #20 clock = ~clock;
  cief_core #(.NBUF(3)) dut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .init_request, .init_ack, .listen_only, .wake_flag, .overrun_flag,
    .rx_full_flag, .rx_err_cnt, .tx_err_cnt, .tx_sent, .abort_done, .buf_sel,
    .tx_schedule, .buf_access_ok, .status_change_flag, .wake_irq, .error_irq,
    .rx_irq, .tx_irq);
  cief_can_model u_can (.clock, .rst_n, .tx_schedule, .abort_mode, .slow,
    .tx_sent, .abort_done);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wrt
  // Read notes its expectation for the monitor
  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask : rdx
  // Bounded wait for all buffers to leave the schedule
  task automatic wait_idle;
    int i;
    // Step off the write edge so the freshly cleared flag is seen
    @(negedge clock);
    for (i = 0; i < 50 && tx_schedule !== 3'h0; i++)
      @(negedge clock);
    if (tx_schedule !== 3'h0)
    begin
      error_cnt++;
      stop_test();
    end
  endtask : wait_idle
  // Read data stands only in the cycle after the strobe
  always @(posedge clock)
    rd_seen <= rd;
  always @(negedge clock)
    if (rd_seen)
      chk("rdata", rdata, exp_q.pop_front());
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    rdx(4'h5, 8'h00);
    rdx(4'h6, 8'h07);
    repeat (3)
    begin
      seed = xs(seed);
      r = seed[7:0];
      wrt(4'h5, r);
      rdx(4'h5, r);
    end
    init_request <= 1'b1;
    init_ack <= 1'b1;
    cyc(4);
    rdx(4'h5, r & 8'h3C);
    wrt(4'h5, 8'hFF);
    wrt(4'h6, 8'h01);
    rdx(4'h5, r & 8'h3C);
    rdx(4'h6, 8'h07);
    init_request <= 1'b0;
    init_ack <= 1'b0;
    listen_only <= 1'b1;
    cyc(4);
    wrt(4'h6, 8'h07);
    rdx(4'h6, 8'h07);
    @(negedge clock);
    chk("tx_schedule", 8'(tx_schedule), 8'h00);
    cyc(1);
    listen_only <= 1'b0;
    slow <= 1'b1;
    cyc(3);
    wrt(4'h7, 8'h07);
    wrt(4'h6, 8'h00);
    rdx(4'h6, 8'h07);
    wrt(4'h6, 8'h01);
    rdx(4'h6, 8'h06);
    @(negedge clock);
    chk("tx_schedule", 8'(tx_schedule), 8'h01);
    chk("tx_irq", 8'(tx_irq), 8'h01);
    wait_idle();
    rdx(4'h6, 8'h07);
    slow <= 1'b0;
    wrt(4'h6, 8'h04);
    wait_idle();
    rdx(4'h6, 8'h07);
    abort_mode <= 1'b1;
    slow <= 1'b1;
    wrt(4'h6, 8'h02);
    wrt(4'h8, 8'h02);
    buf_sel <= 3'h2;
    @(negedge clock);
    chk("buf_access_ok", 8'(buf_access_ok), 8'h00);
    @(posedge clock);
    buf_sel <= 3'h1;
    @(negedge clock);
    chk("buf_access_ok", 8'(buf_access_ok), 8'h01);
    wait_idle();
    rdx(4'h9, 8'h02);
    rdx(4'h8, 8'h00);
    rdx(4'h6, 8'h07);
    abort_mode <= 1'b0;
    wrt(4'h6, 8'h02);
    rdx(4'h9, 8'h00);
    wait_idle();
    // Receiver state changes under two sensitivities
    wrt(4'h5, 8'h70);
    rx_err_cnt <= 9'h064;
    cyc(4);
    rdx(4'h4, 8'h50);
    @(negedge clock);
    chk("error_irq", 8'(error_irq), 8'h01);
    chk("status_change_flag", 8'(status_change_flag), 8'h01);
    cyc(1);
    rx_err_cnt <= 9'h082;
    cyc(4);
    rdx(4'h4, 8'h50);
    wrt(4'h4, 8'h40);
    cyc(4);
    rdx(4'h4, 8'h60);
    wrt(4'h4, 8'h40);
    wrt(4'h5, 8'h50);
    rx_err_cnt <= 9'h000;
    cyc(4);
    rdx(4'h4, 8'h00);
    // Transmitter bus-off entry and exit drag the receiver state along
    wrt(4'h5, 8'h44);
    tx_err_cnt <= 9'h100;
    cyc(4);
    rdx(4'h4, 8'h7C);
    tx_err_cnt <= 9'h000;
    rx_err_cnt <= 9'h082;
    cyc(2);
    wrt(4'h4, 8'h40);
    cyc(4);
    rdx(4'h4, 8'h40);
    wrt(4'h4, 8'h40);
    cyc(4);
    rdx(4'h4, 8'h20);
    rx_err_cnt <= 9'h000;
    @(negedge clock);
    chk("status_change_flag", 8'(status_change_flag), 8'h00);
    // Event enables
    wrt(4'h5, 8'h83);
    wake_flag <= 1'b1;
    overrun_flag <= 1'b1;
    rx_full_flag <= 1'b1;
    cyc(4);
    @(negedge clock);
    chk("wake_irq", 8'(wake_irq), 8'h01);
    chk("error_irq", 8'(error_irq), 8'h01);
    chk("rx_irq", 8'(rx_irq), 8'h01);
    wrt(4'h5, 8'h00);
    wrt(4'h7, 8'h00);
    cyc(2);
    @(negedge clock);
    chk("wake_irq", 8'(wake_irq), 8'h00);
    chk("error_irq", 8'(error_irq), 8'h00);
    chk("rx_irq", 8'(rx_irq), 8'h00);
    chk("tx_irq", 8'(tx_irq), 8'h00);
    @(negedge clock);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
